// ==== src/raster_fifo_underflow_monitor.sv ====
// Purpose: Feeds panel pixel pins from an input FIFO and reports underflow.
// Assumes: Memory side and panel side run on clk_i.
// Notes: Recovery is by dropping raster_enable_i or by controller reset; the monitor self-heals output only after an underflow taken in ST_IDLE.
`timescale 1ns/1ps
`default_nettype none
module raster_fifo_underflow_monitor
  import raster_pkg::*;
#(
  parameter int WIDTH = raster_pkg::PIXEL_W,
  parameter int DEPTH = raster_pkg::FIFO_DEPTH
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        raster_enable_i,
  input  wire logic                        underflow_irq_enable_i,
  input  wire logic                        underflow_clear_i,
  input  wire logic                        mem_valid_i,
  output logic                             mem_ready_o,
  input  wire logic [WIDTH-1:0]            mem_data_i,
  input  wire logic                        pixel_fetch_i,
  output var raster_pkg::pixel_out_t       pixel_o,
  output logic [raster_pkg::STAT_W-1:0]    display_status_reg_o,
  output logic                             fifo_underflow_flag_o,
  output logic                             irq_o
);
  import raster_pkg::*;

  // Fill level counts 0..DEPTH, so it needs one bit above the index width
  localparam int               CNT_W      = $clog2(DEPTH) + 1;
  localparam logic [CNT_W-1:0] LEVEL_FULL = CNT_W'(DEPTH);

  // The carrier is fixed at the package width, and the fill mirror below
  // relies on the same power-of-two depth as the FIFO
  if (WIDTH != PIXEL_W) begin : g_width_check
    $error("pixel width must match the carrier width");
  end
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("fifo depth must be a power of two of at least two");
  end
  if (STAT_W <= STAT_FIFO_EMPTY_BIT || STAT_W <= STAT_UNDERFLOW_BIT) begin : g_stat_check
    $error("status word too narrow for its fields");
  end

  // One pixel beat; used for the reset value and for every fetch answer
  function automatic pixel_out_t make_pixel(
    input logic [PIXEL_W-1:0] data,
    input logic               valid,
    input logic               corrupt
  );
    pixel_out_t beat;
    beat.data    = data;
    beat.valid   = valid;
    beat.corrupt = corrupt;
    return beat;
  endfunction

  // Fill level after one cycle of pushes and pops
  function automatic logic [CNT_W-1:0] level_after(
    input logic [CNT_W-1:0] level,
    input logic             push,
    input logic             pop
  );
    logic [CNT_W-1:0] sum;
    sum = level;
    if (push) begin
      sum = sum + 1'b1;
    end
    if (pop) begin
      sum = sum - 1'b1;
    end
    return sum;
  endfunction

  logic             fifo_ready;
  logic             fifo_valid;
  logic             fifo_empty;
  logic [WIDTH-1:0] fifo_data;
  logic             fetch;
  logic             underflow_evt;

  raster_state_t    state_r;
  raster_state_t    state_nxt;
  pixel_out_t       pix_r;
  pixel_out_t       pix_nxt;
  logic             flag_r;
  logic             flag_nxt;
  logic             irq_r;
  logic             irq_nxt;
  logic             empty_r;
  logic             mem_ready_r;
  logic             mem_ready_nxt;
  logic             mem_push;
  logic             mem_pop;
  logic [CNT_W-1:0] level_r;
  logic [CNT_W-1:0] level_nxt;

  // A refresh stall upstream simply withholds mem_valid_i; the FIFO drains
  // and the next fetch trips the detector
  pixel_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (mem_valid_i),
    .in_ready_o  (fifo_ready),
    .in_data_i   (mem_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fetch),
    .out_data_o  (fifo_data),
    .empty_o     (fifo_empty)
  );

  always_comb begin
    fetch         = raster_enable_i && pixel_fetch_i;
    underflow_evt = fetch && !fifo_valid;
  end

  // Fill level mirror: ready leaves a flop that already knows the next fill
  // level, so the memory side never sees the FIFO's pointer compare directly
  always_comb begin
    mem_push      = mem_valid_i && fifo_ready;
    mem_pop       = fetch && fifo_valid;
    level_nxt     = level_after(level_r, mem_push, mem_pop);
    mem_ready_nxt = (level_nxt != LEVEL_FULL);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_r     <= '0;
      mem_ready_r <= 1'b1;
    end else begin
      level_r     <= level_nxt;
      mem_ready_r <= mem_ready_nxt;
    end
  end

  // Output path state
  always_comb begin
    state_nxt = state_r;
    pix_nxt   = pix_r;
    pix_nxt.valid = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (raster_enable_i) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!raster_enable_i) begin
          state_nxt = ST_IDLE;
        end else if (underflow_evt) begin
          state_nxt = ST_UNDERFLOW;
        end
      end
      ST_UNDERFLOW: begin
        // Stays corrupt until disabled or reset; the panel stream lost sync
        if (!raster_enable_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        // The unused fourth code of the state word falls back to idle
        state_nxt = ST_IDLE;
      end
    endcase
    if (fetch) begin
      // Every corrupt beat carries the known filler, never stale FIFO data
      if (underflow_evt || state_r == ST_UNDERFLOW) begin
        pix_nxt = make_pixel(PIXEL_BAD, 1'b1, 1'b1);
      end else begin
        pix_nxt = make_pixel(fifo_data, 1'b1, 1'b0);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      pix_r   <= make_pixel(PIXEL_RST, 1'b0, 1'b0);
    end else begin
      state_r <= state_nxt;
      pix_r   <= pix_nxt;
    end
  end

  // Status and interrupt state; a new event beats a same-cycle clear
  always_comb begin
    flag_nxt = flag_r;
    if (underflow_clear_i) begin
      flag_nxt = 1'b0;
    end
    if (underflow_evt) begin
      flag_nxt = 1'b1;
    end
    // Irq is taken from the next flag so both flops move on the same edge
    irq_nxt = flag_nxt && underflow_irq_enable_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r      <= 1'b0;
      irq_r       <= 1'b0;
      empty_r     <= 1'b1;
    end else begin
      flag_r      <= flag_nxt;
      irq_r       <= irq_nxt;
      empty_r     <= fifo_empty;
    end
  end

  // Every output leaves a flop; the empty bit lags the FIFO by one cycle
  always_comb begin
    pixel_o                                   = pix_r;
    fifo_underflow_flag_o                     = flag_r;
    irq_o                                     = irq_r;
    mem_ready_o                               = mem_ready_r;
    display_status_reg_o                      = STAT_RST;
    display_status_reg_o[STAT_UNDERFLOW_BIT]  = flag_r;
    display_status_reg_o[STAT_FIFO_EMPTY_BIT] = empty_r;
  end
endmodule // raster_fifo_underflow_monitor
`default_nettype wire

// ==== src/raster_pkg.sv ====
// Purpose: Shared constants and carriers for the raster FIFO underflow monitor.
// Assumes: One functional clock, synchronous active-high reset.
// Notes: Status bit layout and the corrupt filler word are local choices; no bus reaches them
// Function
// - Flag underflow when output logic fetches a pixel word from an empty FIFO.
// - Pixel output during underflow is invalid and is marked corrupt; the code still drives valid high on those beats, with corrupt set.
// - Underflow sets the underflow flag in the display status register.
// - With the interrupt enable set, an underflow raises an interrupt request.
// - Memory refresh is autonomous; a refresh at start-up can starve the FIFO.
package raster_pkg;
  localparam int PIXEL_W   = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [PIXEL_W-1:0] PIXEL_RST = 16'h0000;
  localparam logic [PIXEL_W-1:0] PIXEL_BAD = 16'h0000;
  localparam int STAT_UNDERFLOW_BIT = 0;
  localparam int STAT_FIFO_EMPTY_BIT = 1;
  localparam int STAT_W = 2;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;

  typedef struct packed {
    logic [PIXEL_W-1:0] data;
    logic               valid;
    logic               corrupt;
  } pixel_out_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_UNDERFLOW
  } raster_state_t;
endpackage

// ==== src/pixel_fifo.sv ====
// Purpose: Synchronous pixel FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous reset.
// Notes: Depth must be a power of two.
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  empty_o
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth; anything else is refused
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("pixel_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      wptr_nxt;
  logic [AW:0]      rptr_r;
  logic [AW:0]      rptr_nxt;
  logic             push;
  logic             pop;
  logic             full;

  always_comb begin
    full        = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
    empty_o     = (wptr_r == rptr_r);
    in_ready_o  = !full;
    out_valid_o = !empty_o;
    out_data_o  = mem_r[rptr_r[AW-1:0]];
    push        = in_valid_i && !full;
    pop         = out_ready_i && !empty_o;
    wptr_nxt    = push ? wptr_r + 1'b1 : wptr_r;
    rptr_nxt    = pop ? rptr_r + 1'b1 : rptr_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
    if (push) begin
      mem_r[wptr_r[AW-1:0]] <= in_data_i;
    end
  end
endmodule // pixel_fifo
`default_nettype wire

// ==== bench/underflow_checker_assertions.sv ====
// Purpose: Port-level checks of the underflow monitor
// Assumes: One clock, sync reset
// Notes: Bound to every monitor instance
`timescale 1ns/1ps
`default_nettype none
module underflow_checker
  import raster_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  raster_enable_i,
  input wire logic                  underflow_irq_enable_i,
  input wire logic                  underflow_clear_i,
  input wire logic                  pixel_fetch_i,
  input wire pixel_out_t            pixel_o,
  input wire logic [STAT_W-1:0]     display_status_reg_o,
  input wire logic                  fifo_underflow_flag_o,
  input wire logic                  irq_o
);
  import raster_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_fetch_answered: assert property (raster_enable_i && pixel_fetch_i |=> pixel_o.valid)
    else $error("no pixel");
  a_no_fetch_quiet: assert property (!(raster_enable_i && pixel_fetch_i) |=> !pixel_o.valid)
    else $error("stray pixel");
  a_corrupt_data: assert property (pixel_o.valid && pixel_o.corrupt |-> pixel_o.data == PIXEL_BAD)
    else $error("bad data");
  a_flag_rise: assert property ($rose(fifo_underflow_flag_o) |-> pixel_o.valid && pixel_o.corrupt)
    else $error("flag cause");
  a_status_flag: assert property (display_status_reg_o[STAT_UNDERFLOW_BIT] == fifo_underflow_flag_o)
    else $error("status");
  a_irq_flag: assert property (irq_o |-> fifo_underflow_flag_o)
    else $error("irq without flag");
  a_irq_follows_flag: assert property (irq_o == (fifo_underflow_flag_o && $past(underflow_irq_enable_i)))
    else $error("irq not following flag");
  a_flag_sticky: assert property ($past(fifo_underflow_flag_o) && !$past(underflow_clear_i) |-> fifo_underflow_flag_o)
    else $error("flag lost");
  a_clear_works: assert property ($past(underflow_clear_i) && !(pixel_o.valid && pixel_o.corrupt) |-> !fifo_underflow_flag_o)
    else $error("clear ignored");
endmodule // underflow_checker
bind raster_fifo_underflow_monitor underflow_checker u_chk (.clk_i, .rst_i, .raster_enable_i, .underflow_irq_enable_i,
  .underflow_clear_i, .pixel_fetch_i, .pixel_o, .display_status_reg_o, .fifo_underflow_flag_o, .irq_o);
`default_nettype wire

// ==== bench/panel_model.sv ====
// Purpose: Panel that counts good and corrupt pixels
// Assumes: Pixel valid is a one-cycle pulse
// Notes: Corrupt pixels are dropped, not shown
`timescale 1ns/1ps
`default_nettype none
module panel_model
  import raster_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire pixel_out_t pixel_i,
  output logic [7:0]      good_o,
  output logic [7:0]      bad_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      good_o <= 8'h00;
      bad_o  <= 8'h00;
    end else if (pixel_i.valid) begin
      if (pixel_i.corrupt) bad_o <= bad_o + 8'h01;
      else good_o <= good_o + 8'h01;
    end
  end
endmodule // panel_model
`default_nettype wire

// ==== bench/raster_fifo_underflow_monitor_tb.sv ====
// Purpose: Self-checking bench of the underflow monitor
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Random pixel words, fixed seed
`timescale 1ns/1ps
`default_nettype none
module raster_fifo_underflow_monitor_tb;
  import raster_pkg::*;
  logic clk_i = 0, rst_i = 1, ren = 0, ien = 0, clr = 0, mv = 0, fch = 0, mrdy, flag, irq;
  logic [15:0] md = 16'h0000, q[$];
  logic [1:0] stat;
  logic [7:0] good, bad;
  pixel_out_t px;
  int error_cnt = 0, checked = 0, seed = 25789, n = 0;
  raster_fifo_underflow_monitor u_dut (.clk_i, .rst_i, .raster_enable_i(ren), .underflow_irq_enable_i(ien),
    .underflow_clear_i(clr), .mem_valid_i(mv), .mem_ready_o(mrdy), .mem_data_i(md), .pixel_fetch_i(fch),
    .pixel_o(px), .display_status_reg_o(stat), .fifo_underflow_flag_o(flag), .irq_o(irq));
  panel_model u_panel (.clk_i, .rst_i, .pixel_i(px), .good_o(good), .bad_o(bad));
  initial forever #5 clk_i = ~clk_i;
  task step; @(posedge clk_i); #1; endtask
  // Expected beat {valid, corrupt, data}: a corrupt beat always carries the filler
  function automatic logic [17:0] exp_px(input logic bad_beat, input logic [15:0] word);
    return {1'b1, bad_beat, bad_beat ? PIXEL_BAD : word};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (2) step;
    rst_i = 0;
    chk({flag, irq, stat}, 4'h2);
    ren = 1;
    ien = 1;
    for (int i = 0; i < 8; i++) begin
      mv = 1;
      md = $random(seed);
      q.push_back(md);
      step;
    end
    mv = 0;
    chk(mrdy, 1'b0);
    fch = 1;
    for (int i = 0; i < 8; i++) begin
      step;
      chk({px.valid, px.corrupt, px.data}, exp_px(1'b0, q[i]));
    end
    step;
    fch = 0;
    chk({px.valid, px.corrupt, px.data}, exp_px(1'b1, q[0]));
    chk({flag, irq, stat[0]}, 3'h7);
    step;
    chk(flag, 1'b1);
    clr = 1;
    step;
    clr = 0;
    chk({flag, irq}, 2'h0);
    ien = 0;
    fch = 1;
    step;
    chk({flag, irq}, 2'h2);
    ren = 0;
    step;
    fch = 0;
    chk(px.valid, 1'b0);
    chk({good, bad}, 16'h0802);
    rst_i = 1;
    repeat (2) step;
    rst_i = 0;
    chk(flag, 1'b0);
    chk({mrdy, stat}, 3'h6);
    // Random short burst, then an underflow and a clear in the same cycle
    q.delete();
    n = ($random(seed) & 3) + 1;
    ren = 1;
    ien = 1;
    for (int i = 0; i < n; i++) begin
      mv = 1;
      md = $random(seed);
      q.push_back(md);
      step;
    end
    mv = 0;
    fch = 1;
    for (int i = 0; i < n; i++) begin
      step;
      chk({px.valid, px.corrupt, px.data}, exp_px(1'b0, q[i]));
    end
    clr = 1;
    step;
    clr = 0;
    fch = 0;
    chk({flag, irq}, 2'h3);
    chk({px.valid, px.corrupt, px.data}, exp_px(1'b1, q[0]));
    mv = 1;
    md = $random(seed);
    step;
    mv = 0;
    fch = 1;
    step;
    fch = 0;
    chk({px.valid, px.corrupt, px.data}, exp_px(1'b1, md));
    chk(stat, 2'h1);
    ien = 0;
    step;
    chk({flag, irq}, 2'h2);
    chk({good, bad}, {n[7:0], 8'h02});
    end_of_test;
  end
endmodule // raster_fifo_underflow_monitor_tb
`default_nettype wire
